// ===== common/counter_meas_regs.svh
`ifndef COUNTER_MEAS_REGS_SVH
`define COUNTER_MEAS_REGS_SVH

// Register byte offsets inside one channel window
`define OFS_MODE        5'h00
`define OFS_PRE0        5'h04
`define OFS_PRE1        5'h08
`define OFS_LATCH       5'h0c
`define OFS_COUNT       5'h10
`define OFS_CMD         5'h14
// Global gate half-period register
`define OFS_GATE        8'h80

// Command register bits (write one to act, read as zero)
`define CMD_LATCH       0
`define CMD_PRELOAD     1

// Clock mode codes
`define CLK_QUAD_X2     3'h2
`define CLK_QUAD_X4     3'h3
`define CLK_SINGLE      3'h4
`define CLK_SINGLE_X2   3'h5
`define CLK_SINGLE_ALT  3'h6
`define CLK_INTERNAL    3'h7

// Trigger field codes and index source code
`define TRIG_NONE       2'h0
`define TRIG_INDEX      2'h1
`define SRC_GATE        1'b1

// Reset values
`define MODE_RST        17'h0_0007
`define GATE_PER_RST    32'h000f_423f

// Timing
`define SYS_CLK_HZ      100000000
`define INT_CLK_HZ      10000000
`define INT_DIV         (`SYS_CLK_HZ / `INT_CLK_HZ)

`endif

// ===== common/counter_meas_pkg.sv
package counter_meas_pkg;

  typedef struct packed {
    logic       out_pol;
    logic [1:0] out_mode;
    logic       idx_src;
    logic       preload_mode_field;
    logic [1:0] cd;
    logic [1:0] count_enable_trigger_field;
    logic [1:0] lat_sel;
    logic [1:0] pl_trig;
    logic       idx_pol;
    logic [2:0] clk_mode;
  } mode_t;

  typedef struct packed {
    logic clk_a;
    logic clk_b;
    logic index;
  } pins_t;

  typedef struct packed {
    mode_t       mode;
    logic [31:0] pre0;
    logic [31:0] pre1;
    logic [31:0] cnt;
    logic [31:0] lat;
    logic        run;
    logic        idx_prev;
    logic        use_pre1;
    logic [2:0]  a_s;
    logic [2:0]  b_s;
    logic [2:0]  x_s;
  } chan_t;

  typedef struct packed {
    chan_t [3:0] ch;
    logic [3:0]  div;
    logic [31:0] gate_per;
    logic [31:0] gate_cnt;
    logic        gate;
    logic [31:0] rdata;
  } state_t;

endpackage : counter_meas_pkg

// ===== hw/counter_meas.sv
// Operation
// - Index leading edge starts counting when enabled
// - Index trailing edge stops counting when selected
// - Index leading edge copies count into latch
// - Latch each result, restart, latch always readable
// - Index leading edge loads first preload register, alternating with second in preload mode
// - Period mode counts from first leading edge
// - Clock mode 4 counts first clock input
// - Index source picks pin or shared gate
// - Index polarity 0 means active high
// - Gated counting only while gate is active
// - High second clock input counts upward in single-clock and internal modes
// - Accept 10/5/2.5 MHz input rates
`timescale 1ns/1ns
`include "counter_meas_regs.svh"

module counter_meas (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Counter pins, one group per channel
  input  wire counter_meas_pkg::pins_t [3:0] pins,
  // Shared time gate
  output logic                               time_gate
);

  counter_meas_pkg::state_t s_reg;
  counter_meas_pkg::state_t s_next;

  logic int_tick;
  logic acc;
  logic wr;

  function automatic logic addr_ok(input logic [7:0] a);
    if (a[1:0] != 2'h0)
      addr_ok = 1'b0;
    else if (a[7])
      addr_ok = (a == `OFS_GATE);
    else
      addr_ok = (a[4:0] <= `OFS_CMD);
  endfunction : addr_ok

  function automatic logic [31:0] quad_step(
    input logic [2:0] md,
    input logic       a,
    input logic       ap,
    input logic       b,
    input logic       bp
  );
    logic tick;
    logic up;
    tick = 1'b0;
    up   = a ^ bp;
    if (md == `CLK_QUAD_X4)
      tick = (a ^ ap) | (b ^ bp);
    else if (md == `CLK_QUAD_X2)
      tick = a ^ ap;
    else
      tick = a & ~ap;
    if (!tick)
      quad_step = 32'h0000_0000;
    else if (up)
      quad_step = 32'h0000_0001;
    else
      quad_step = 32'hffff_ffff;
  endfunction : quad_step

  assign acc       = psel & penable;
  assign wr        = acc & pwrite & addr_ok(paddr);
  assign pready    = 1'b1;
  assign pslverr   = acc & ~addr_ok(paddr);
  assign prdata    = s_reg.rdata;
  assign time_gate = s_reg.gate;

  always_comb begin
    logic [31:0] step;
    logic        idx;
    logic        act;
    logic        lead;
    logic        trail;
    logic        tick;
    logic [1:0]  ci;
    step   = 32'h0000_0000;
    idx    = 1'b0;
    act    = 1'b0;
    lead   = 1'b0;
    trail  = 1'b0;
    tick   = 1'b0;
    ci     = paddr[6:5];
    s_next = s_reg;

    // Internal count clock as a one-cycle enable
    int_tick = (s_reg.div == 4'(`INT_DIV - 1));
    s_next.div = int_tick ? 4'h0 : s_reg.div + 4'h1;

    // Shared time gate: square wave, half-period in internal ticks
    if (int_tick) begin
      if (s_reg.gate_cnt >= s_reg.gate_per) begin
        s_next.gate_cnt = 32'h0000_0000;
        s_next.gate     = ~s_reg.gate;
      end else begin
        s_next.gate_cnt = s_reg.gate_cnt + 32'h0000_0001;
      end
    end

    for (int i = 0; i < 4; i++) begin
      // Two-stage synchronisers, third stage holds the previous level
      s_next.ch[i].a_s = {s_reg.ch[i].a_s[1:0], pins[i].clk_a};
      s_next.ch[i].b_s = {s_reg.ch[i].b_s[1:0], pins[i].clk_b};
      s_next.ch[i].x_s = {s_reg.ch[i].x_s[1:0], pins[i].index};

      // Index routing and polarity
      idx = (s_reg.ch[i].mode.idx_src == `SRC_GATE) ?
            s_reg.gate : s_reg.ch[i].x_s[1];
      act   = idx ^ s_reg.ch[i].mode.idx_pol;
      lead  = act & ~s_reg.ch[i].idx_prev;
      trail = ~act & s_reg.ch[i].idx_prev;
      s_next.ch[i].idx_prev = act;

      // Count source and direction
      unique case (s_reg.ch[i].mode.clk_mode)
        `CLK_INTERNAL:
          tick = int_tick;
        `CLK_SINGLE, `CLK_SINGLE_ALT:
          tick = s_reg.ch[i].a_s[1] & ~s_reg.ch[i].a_s[2];
        `CLK_SINGLE_X2:
          tick = s_reg.ch[i].a_s[1] ^ s_reg.ch[i].a_s[2];
        default:
          tick = 1'b0;
      endcase
      if (s_reg.ch[i].mode.clk_mode >= `CLK_SINGLE)
        step = !tick ? 32'h0000_0000 :
               s_reg.ch[i].b_s[1] ? 32'h0000_0001 :
               32'hffff_ffff;
      else
        step = quad_step(s_reg.ch[i].mode.clk_mode,
                         s_reg.ch[i].a_s[1], s_reg.ch[i].a_s[2],
                         s_reg.ch[i].b_s[1], s_reg.ch[i].b_s[2]);

      // Enable and disable
      if (s_reg.ch[i].mode.count_enable_trigger_field == `TRIG_NONE)
        s_next.ch[i].run = 1'b1;
      else if (s_reg.ch[i].mode.count_enable_trigger_field == `TRIG_INDEX && lead)
        s_next.ch[i].run = 1'b1;
      if (s_reg.ch[i].mode.cd == `TRIG_INDEX && trail)
        s_next.ch[i].run = 1'b0;

      // Count; a gated channel counts only while its gate is active
      if (s_reg.ch[i].run &&
          (s_reg.ch[i].mode.idx_src != `SRC_GATE || act))
        s_next.ch[i].cnt = s_reg.ch[i].cnt + step;

      // Latch the finished measurement on the leading edge
      if (s_reg.ch[i].mode.lat_sel == `TRIG_INDEX && lead)
        s_next.ch[i].lat = s_reg.ch[i].cnt;

      // Preload restarts the next measurement
      if (s_reg.ch[i].mode.pl_trig == `TRIG_INDEX && lead) begin
        s_next.ch[i].cnt = s_reg.ch[i].use_pre1 ?
                           s_reg.ch[i].pre1 : s_reg.ch[i].pre0;
        s_next.ch[i].use_pre1 = s_reg.ch[i].mode.preload_mode_field &
                                ~s_reg.ch[i].use_pre1;
      end
    end

    // Register writes
    if (wr) begin
      if (paddr[7]) begin
        s_next.gate_per = pwdata;
      end else begin
        unique case (paddr[4:0])
          `OFS_MODE: begin
            s_next.ch[ci].mode = counter_meas_pkg::mode_t'(pwdata[16:0]);
            s_next.ch[ci].use_pre1 = 1'b0;
          end
          `OFS_PRE0:
            s_next.ch[ci].pre0 = pwdata;
          `OFS_PRE1:
            s_next.ch[ci].pre1 = pwdata;
          `OFS_CMD: begin
            if (pwdata[`CMD_LATCH])
              s_next.ch[ci].lat = s_reg.ch[ci].cnt;
            if (pwdata[`CMD_PRELOAD])
              s_next.ch[ci].cnt = s_reg.ch[ci].pre0;
          end
          default: begin
          end
        endcase
      end
    end

    // Read data captured in the setup cycle
    if (psel && !penable && !pwrite) begin
      s_next.rdata = 32'h0000_0000;
      if (addr_ok(paddr)) begin
        if (paddr[7]) begin
          s_next.rdata = s_reg.gate_per;
        end else begin
          unique case (paddr[4:0])
            `OFS_MODE:
              s_next.rdata = {15'h0000, s_reg.ch[ci].mode};
            `OFS_PRE0:
              s_next.rdata = s_reg.ch[ci].pre0;
            `OFS_PRE1:
              s_next.rdata = s_reg.ch[ci].pre1;
            `OFS_LATCH:
              s_next.rdata = s_reg.ch[ci].lat;
            `OFS_COUNT:
              s_next.rdata = s_reg.ch[ci].cnt;
            default:
              s_next.rdata = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.gate_per <= `GATE_PER_RST;
      for (int i = 0; i < 4; i++) begin
        s_reg.ch[i].mode <= counter_meas_pkg::mode_t'(`MODE_RST);
      end
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : counter_meas

// ===== verification/counter_meas_properties.sv
`timescale 1ns/1ns
module counter_meas_properties (
  // Clock and reset
  input wire logic                          pclk,
  input wire logic                          presetn,
  // APB
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [7:0]                    paddr,
  input wire logic [31:0]                   pwdata,
  input wire logic [31:0]                   prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  // Pins and gate
  input wire counter_meas_pkg::pins_t [3:0] pins,
  input wire logic                          time_gate
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic in_win;
  assign acc = psel && penable;
  assign in_win = paddr < 8'h80;
  a_ready_high: assert property (psel |-> pready)
    else $error("ready low");
  a_err_unalign: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("no error on unaligned");
  a_err_hole: assert property (acc && in_win && paddr[4:0] > 5'h14 |-> pslverr)
    else $error("no error on hole");
  a_ok_mapped: assert property (acc && in_win && paddr[1:0] == 2'h0
    && paddr[4:0] <= 5'h14 |-> !pslverr)
    else $error("error on mapped");
  a_err_quiet: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  a_cmd_zero: assert property (acc && !pwrite && in_win
    && paddr[4:0] == 5'h14 |-> prdata == 32'h0000_0000)
    else $error("command reads nonzero");
  a_read_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved");
  a_gate_hold: assert property ($changed(time_gate) |=>
    $stable(time_gate) [*8])
    else $error("gate too short");
endmodule : counter_meas_properties

bind counter_meas counter_meas_properties counter_meas_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins(pins), .time_gate(time_gate));

// ===== verification/pin_source.sv
`timescale 1ns/1ns
module pin_source (
  // Clock
  input wire logic                      pclk,
  // Channel pins
  output counter_meas_pkg::pins_t [3:0] pins
);
  int t = 0;
  // Ch0 pulses 200 wide, ch1 period 300, ch2 clock period 20
  // Ch3 idles with B high, then runs quadrature with A leading B
  always @(posedge pclk) begin
    t <= t + 1;
    pins[0] <= {1'b0, 1'b1, (t % 500) < 200};
    pins[1] <= {1'b0, 1'b1, (t % 300) < 150};
    pins[2] <= {(t % 20) < 10, 1'b1, 1'b0};
    pins[3] <= (t < 1000) ? 3'b010 :
               {(t % 40) < 20, ((t + 30) % 40) < 20, 1'b0};
  end
endmodule : pin_source

// ===== verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic                          pclk;
  logic                          presetn;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [7:0]                    paddr;
  logic [31:0]                   pwdata;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  logic                          time_gate;
  logic [31:0]                   v;
  logic [31:0]                   c;
  logic                          e;
  counter_meas_pkg::pins_t [3:0] pins;
  logic [31:0]                   md [3] = '{32'h557, 32'h157, 32'h2154};
  int                            err_total = 0;
  int                            n_checks = 0;

  counter_meas counter_meas_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .time_gate(time_gate));
  pin_source pin_source_inst (.pclk(pclk), .pins(pins));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task chk(input logic [31:0] got, input logic [31:0] exp,
           input logic [31:0] tol);
    n_checks++;
    if (got >= exp - tol && got <= exp + tol) begin
    end else begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    summarize();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b1, 8'h80, 32'h9);
    xfer(1'b0, 8'h60, 32'h0);
    chk(v, 32'h7, 32'h0);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 8'(i * 32 + 4), 32'h0);
      xfer(1'b1, 8'(i * 32), md[i]);
    end
    // Free-running channel 3 climbs about 10 ticks per 103 cycles
    xfer(1'b0, 8'h70, 32'h0);
    c = v;
    repeat (100) @(posedge pclk);
    xfer(1'b0, 8'h70, 32'h0);
    chk(v - c, 32'd10, 32'd1);
    repeat (1500) @(posedge pclk);
    xfer(1'b0, 8'h0c, 32'h0);
    chk(v, 32'd20, 32'd1);
    xfer(1'b0, 8'h2c, 32'h0);
    chk(v, 32'd30, 32'd1);
    xfer(1'b0, 8'h4c, 32'h0);
    chk(v, 32'd5, 32'd1);
    repeat (500) @(posedge pclk);
    xfer(1'b0, 8'h0c, 32'h0);
    chk(v, 32'd20, 32'd1);
    xfer(1'b0, 8'h18, 32'h0);
    chk({31'h0, e}, 32'h1, 32'h0);
    xfer(1'b0, 8'h74, 32'h0);
    chk(v, 32'h0, 32'h0);
    // Shared gate: half-period of (9 + 1) internal ticks of 10 cycles
    xfer(1'b0, 8'h80, 32'h0);
    chk(v, 32'h9, 32'h0);
    e = time_gate;
    do @(posedge pclk); while (time_gate === e);
    c = 32'h0;
    do begin
      @(posedge pclk);
      c = c + 32'h1;
    end while (time_gate !== e);
    chk(c, 32'h64, 32'h0);
    // Channel 3 in quadrature x4 with A leading B counts up
    xfer(1'b1, 8'h60, 32'h3);
    xfer(1'b0, 8'h70, 32'h0);
    c = v;
    repeat (100) @(posedge pclk);
    xfer(1'b0, 8'h70, 32'h0);
    chk(v - c, 32'ha, 32'h1);
    // Soft preload from the first preload register, then soft latch
    xfer(1'b1, 8'h64, 32'h1000);
    xfer(1'b1, 8'h74, 32'h2);
    xfer(1'b1, 8'h74, 32'h1);
    xfer(1'b0, 8'h6c, 32'h0);
    chk(v, 32'h1000, 32'h1);
    summarize();
  end
endmodule : testbench
